/* hdl/gcd_pkg.sv */
// gcd_pkg: shared constants and carriers of the graphics controller datapath.
// assumes a single core clock; all i/o addresses are 16-bit host port numbers.
`default_nettype none

package gcd_pkg;

    // host i/o port numbers
    localparam logic [15:0] GCD_PORT_GC_INDEX   = 16'h03ce;
    localparam logic [15:0] GCD_PORT_GC_DATA    = 16'h03cf;
    localparam logic [15:0] GCD_PORT_CRT_IDX_M  = 16'h03b4;
    localparam logic [15:0] GCD_PORT_CRT_DAT_M  = 16'h03b5;
    localparam logic [15:0] GCD_PORT_CRT_IDX_C  = 16'h03d4;
    localparam logic [15:0] GCD_PORT_CRT_DAT_C  = 16'h03d5;

    // indices behind the data port
    localparam logic [3:0] GCD_IDX_FILL_VALUE   = 4'h0;
    localparam logic [3:0] GCD_IDX_FILL_ENABLE  = 4'h1;
    localparam logic [3:0] GCD_IDX_COMPARE      = 4'h2;
    localparam logic [3:0] GCD_IDX_ROTATE_FUNC  = 4'h3;
    localparam logic [3:0] GCD_IDX_READ_PLANE   = 4'h4;
    localparam logic [3:0] GCD_IDX_GFX_MODE     = 4'h5;
    localparam logic [3:0] GCD_IDX_MISC         = 4'h6;
    localparam logic [3:0] GCD_IDX_DONT_CARE    = 4'h7;
    localparam logic [3:0] GCD_IDX_BIT_MASK     = 4'h8;
    localparam logic [7:0] GCD_CRT_IDX_LATCH_RB = 8'h22;

    // field positions
    localparam int GCD_ROT_LSB      = 0;
    localparam int GCD_FUNC_LSB     = 3;
    localparam int GCD_WMODE_LSB    = 0;
    localparam int GCD_RDMODE_BIT   = 3;
    localparam int GCD_CGA_OE_BIT   = 4;
    localparam int GCD_MISC_OE_BIT  = 1;

    // writable-bit masks; everything else reads as zero
    localparam logic [7:0] GCD_WMASK_NIBBLE = 8'h0f;
    localparam logic [7:0] GCD_WMASK_ROTFN  = 8'h1f;
    localparam logic [7:0] GCD_WMASK_RDSEL  = 8'h03;
    localparam logic [7:0] GCD_WMASK_MODE   = 8'h7b;
    localparam logic [7:0] GCD_WMASK_FULL   = 8'hff;

    // reset value of every index and data field
    localparam logic [7:0] GCD_RST_VALUE    = 8'h00;

    // write modes and logic functions
    localparam logic [1:0] GCD_WM_HOST_FILL = 2'h0;
    localparam logic [1:0] GCD_WM_LATCH     = 2'h1;
    localparam logic [1:0] GCD_WM_BIT_FILL  = 2'h2;
    localparam logic [1:0] GCD_WM_MASKED    = 2'h3;
    localparam logic [1:0] GCD_FN_MOVE      = 2'h0;
    localparam logic [1:0] GCD_FN_AND       = 2'h1;
    localparam logic [1:0] GCD_FN_OR        = 2'h2;
    localparam logic [1:0] GCD_FN_XOR       = 2'h3;

    // host i/o request, one cycle wide
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } gcd_io_req_s;

    // host display memory request, one cycle wide
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       a0;
        logic [7:0] wdata;
    } gcd_mem_req_s;

endpackage : gcd_pkg

`default_nettype wire

/* hdl/gcd_plane_lane.sv */
// gcd_plane_lane: write data path of one display map (source pick, alu, mask).
// purely combinational; the parent registers the result.
`default_nettype none

module gcd_plane_lane
    import gcd_pkg::*;
(
    input  wire logic [1:0] wmode,
    input  wire logic [1:0] func,
    input  wire logic       fill_bit,
    input  wire logic       fill_en,
    input  wire logic [7:0] host_rot,
    input  wire logic       host_bit,
    input  wire logic [7:0] bit_mask,
    input  wire logic [7:0] latch,
    output logic      [7:0] result
);

    logic [7:0] src;
    logic [7:0] alu;
    logic [7:0] eff_mask;

    // pick the source byte per write mode
    always_comb begin
        src      = host_rot;
        eff_mask = bit_mask;
        case (wmode)
            GCD_WM_HOST_FILL: src = fill_en ? {8{fill_bit}} : host_rot; // RULE2 RULE3 RULE4
            GCD_WM_BIT_FILL:  src = {8{host_bit}};                      // RULE12
            GCD_WM_MASKED: begin
                src      = {8{fill_bit}};       // enable bits ignored here
                eff_mask = bit_mask & host_rot; // RULE12
            end
            default:          src = host_rot;
        endcase
    end

    // logic function against the latched byte
    always_comb begin
        case (func)
            GCD_FN_AND: alu = src & latch; // RULE7
            GCD_FN_OR:  alu = src | latch;
            GCD_FN_XOR: alu = src ^ latch;
            default:    alu = src;
        endcase
    end

    // mask keeps latched bits where it is zero; mode 1 copies the latch whole
    always_comb begin
        if (wmode == GCD_WM_LATCH) begin
            result = latch; // RULE12
        end else begin
            result = (alu & eff_mask) | (latch & ~eff_mask); // RULE14
        end
    end

endmodule : gcd_plane_lane

`default_nettype wire

/* hdl/gcd_datapath.sv */
// gcd_datapath: graphics controller datapath between host i/o, host memory
// accesses and the four display maps.
// assumes host requests and map read data come from logic on CLK, so no
// synchronisers; map read data is valid in the cycle of the read request.
//
// How it works
// RULE1: index register selects data port target
// RULE2: mode 0 writes fill value where enabled
// RULE3: fill bit replicated over all eight bits
// RULE4: per-map enable chooses fill over host
// RULE5: compare read returns per-bit all-maps match
// RULE6: normal read returns selected map byte
// RULE7: two-bit function: move, and, or, xor
// RULE8: rotate host data right, not mode 2
// RULE9: map select picks read map, normal only
// RULE10: odd/even chains maps 0-1 or 2-3
// RULE11: latch readback picks latch by map select
// RULE12: write mode field selects four write behaviours
// RULE13: read mode bit selects compare read
// RULE14: mask zero keeps latch, one passes data
// RULE15: don't care enables per-map compare
// RULE16: memory read loads all four latches
// RULE17: reset clears index and data fields
`default_nettype none

module gcd_datapath
    import gcd_pkg::*;
#(
    parameter int NUM_PLANES = 4
)(
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire logic         SOFT_RST,
    input  wire gcd_io_req_s  IO_REQ,
    output logic       [7:0]  IO_RDATA,
    output logic              IO_RVALID,
    input  wire gcd_mem_req_s MEM_REQ,
    output logic       [7:0]  MEM_RDATA,
    output logic              MEM_RVALID,
    input  wire logic  [3:0]  MAP_ENABLE,
    input  wire logic  [31:0] PLANE_RDATA,
    output logic       [31:0] PLANE_WDATA,
    output logic       [3:0]  PLANE_WE
);

    // the map count is fixed by the four-bit fill, compare and enable fields
    if (NUM_PLANES != 4) begin : g_bad_planes
        $error("gcd_datapath supports exactly four display maps");
    end

    // register fields
    // reserved bits are masked on write so reads show them as zero
    logic [7:0] gc_index;
    logic [7:0] crt_index;
    logic [7:0] fill_value;
    logic [7:0] fill_enable;
    logic [7:0] compare_value;
    logic [7:0] rotate_and_function;
    logic [7:0] read_plane_select;
    logic [7:0] gfx_mode;
    logic [7:0] misc_mode;
    logic [7:0] dont_care;
    logic [7:0] bit_mask;
    logic [7:0] latch [NUM_PLANES];

    // decoded controls
    logic       gc_idx_hit;
    logic       gc_dat_hit;
    logic       crt_idx_hit;
    logic       crt_dat_hit;
    logic [1:0] wmode;
    logic [1:0] func;
    logic [2:0] rot_cnt;
    logic       compare_read;
    logic       odd_even;
    logic [1:0] rd_plane;
    logic [7:0] host_rot;
    logic [15:0] rot_pair;
    logic [7:0] plane_byte [NUM_PLANES];
    logic [7:0] lane_out [NUM_PLANES];
    logic [7:0] cmp_result;
    logic [7:0] next_io_rdata;
    logic [7:0] next_mem_rdata;
    logic [3:0] next_we;
    logic       soft_clear;

    // port decode and field extraction; the soft clear is already on CLK
    assign soft_clear   = SOFT_RST;
    assign gc_idx_hit   = IO_REQ.addr == GCD_PORT_GC_INDEX;
    assign gc_dat_hit   = IO_REQ.addr == GCD_PORT_GC_DATA;
    assign crt_idx_hit  = (IO_REQ.addr == GCD_PORT_CRT_IDX_M) ||
                          (IO_REQ.addr == GCD_PORT_CRT_IDX_C);
    assign crt_dat_hit  = (IO_REQ.addr == GCD_PORT_CRT_DAT_M) ||
                          (IO_REQ.addr == GCD_PORT_CRT_DAT_C);
    assign wmode        = gfx_mode[GCD_WMODE_LSB +: 2];
    assign func         = rotate_and_function[GCD_FUNC_LSB +: 2];
    assign rot_cnt      = rotate_and_function[GCD_ROT_LSB +: 3];
    assign compare_read = gfx_mode[GCD_RDMODE_BIT]; // RULE13
    assign odd_even     = misc_mode[GCD_MISC_OE_BIT] | gfx_mode[GCD_CGA_OE_BIT];

    // rotate right by doubling the byte; mode 2 takes raw data bits instead
    // a plain 16-bit shift then needs no wrap-around logic
    assign rot_pair = {MEM_REQ.wdata, MEM_REQ.wdata} >> rot_cnt;
    assign host_rot = rot_pair[7:0]; // RULE8

    // odd/even chains the pair named by the high select bit, a0 picks within
    always_comb begin
        if (odd_even) begin
            rd_plane = {read_plane_select[1], MEM_REQ.a0}; // RULE10
        end else begin
            rd_plane = read_plane_select[1:0]; // RULE9
        end
    end

    // split map read data into bytes and build the per-map write bytes
    for (genvar p = 0; p < NUM_PLANES; p++) begin : g_plane
        assign plane_byte[p] = PLANE_RDATA[p*8 +: 8];
        gcd_plane_lane u_lane (
            .wmode    (wmode),
            .func     (func),
            .fill_bit (fill_value[p]),
            .fill_en  (fill_enable[p]),
            .host_rot (host_rot),
            .host_bit (MEM_REQ.wdata[p]),
            .bit_mask (bit_mask),
            .latch    (latch[p]),
            .result   (lane_out[p])
        );
    end

    // a map whose don't care bit is clear always counts as matching
    // compare runs every cycle; only a read in compare mode returns it
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            cmp_result[b] = 1'b1;
            for (int p = 0; p < NUM_PLANES; p++) begin
                if (dont_care[p] && (plane_byte[p][b] != compare_value[p])) begin // RULE15
                    cmp_result[b] = 1'b0; // RULE5
                end
            end
        end
    end

    // host memory read answer
    always_comb begin
        if (compare_read) begin
            next_mem_rdata = cmp_result; // RULE5
        end else begin
            next_mem_rdata = plane_byte[rd_plane]; // RULE6
        end
    end

    // odd/even writes only reach the even or odd maps picked by a0
    // the sequencer's map enable still applies; odd/even can only narrow it
    always_comb begin
        next_we = MAP_ENABLE;
        if (odd_even) begin
            next_we = MAP_ENABLE & (MEM_REQ.a0 ? 4'ha : 4'h5);
        end
    end

    // host i/o read mux; reserved bits read as zero from the stored masks
    always_comb begin
        next_io_rdata = 8'h00;
        if (gc_idx_hit) begin
            next_io_rdata = gc_index;
        end else if (crt_idx_hit) begin
            next_io_rdata = crt_index;
        end else if (crt_dat_hit && crt_index == GCD_CRT_IDX_LATCH_RB) begin
            next_io_rdata = latch[read_plane_select[1:0]]; // RULE11
        end else if (gc_dat_hit) begin
            case (gc_index[3:0]) // RULE1
                GCD_IDX_FILL_VALUE:  next_io_rdata = fill_value;
                GCD_IDX_FILL_ENABLE: next_io_rdata = fill_enable;
                GCD_IDX_COMPARE:     next_io_rdata = compare_value;
                GCD_IDX_ROTATE_FUNC: next_io_rdata = rotate_and_function;
                GCD_IDX_READ_PLANE:  next_io_rdata = read_plane_select;
                GCD_IDX_GFX_MODE:    next_io_rdata = gfx_mode;
                GCD_IDX_MISC:        next_io_rdata = misc_mode;
                GCD_IDX_DONT_CARE:   next_io_rdata = dont_care;
                GCD_IDX_BIT_MASK:    next_io_rdata = bit_mask;
                default:             next_io_rdata = 8'h00;
            endcase
        end
    end

    // index registers; upper graphics index bits are read-only zero
    // soft clear is synchronous, so it takes effect at the next edge only
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gc_index  <= GCD_RST_VALUE; // RULE17
            crt_index <= GCD_RST_VALUE;
        end else if (soft_clear) begin
            gc_index  <= GCD_RST_VALUE; // RULE17
            crt_index <= GCD_RST_VALUE;
        end else if (IO_REQ.wr && gc_idx_hit) begin
            gc_index  <= IO_REQ.wdata & GCD_WMASK_NIBBLE; // RULE1
        end else if (IO_REQ.wr && crt_idx_hit) begin
            crt_index <= IO_REQ.wdata;
        end
    end

    // data fields behind the graphics data port
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            fill_value          <= GCD_RST_VALUE; // RULE17
            fill_enable         <= GCD_RST_VALUE;
            compare_value       <= GCD_RST_VALUE;
            rotate_and_function <= GCD_RST_VALUE;
            read_plane_select   <= GCD_RST_VALUE;
            gfx_mode            <= GCD_RST_VALUE;
            misc_mode           <= GCD_RST_VALUE;
            dont_care           <= GCD_RST_VALUE;
            bit_mask            <= GCD_RST_VALUE;
        end else if (soft_clear) begin
            fill_value          <= GCD_RST_VALUE; // RULE17
            fill_enable         <= GCD_RST_VALUE;
            compare_value       <= GCD_RST_VALUE;
            rotate_and_function <= GCD_RST_VALUE;
            read_plane_select   <= GCD_RST_VALUE;
            gfx_mode            <= GCD_RST_VALUE;
            misc_mode           <= GCD_RST_VALUE;
            dont_care           <= GCD_RST_VALUE;
            bit_mask            <= GCD_RST_VALUE;
        end else if (IO_REQ.wr && gc_dat_hit) begin
            case (gc_index[3:0]) // RULE1
                GCD_IDX_FILL_VALUE:  fill_value  <= IO_REQ.wdata & GCD_WMASK_NIBBLE;
                GCD_IDX_FILL_ENABLE: fill_enable <= IO_REQ.wdata & GCD_WMASK_NIBBLE; // RULE4
                GCD_IDX_COMPARE:     compare_value <= IO_REQ.wdata & GCD_WMASK_NIBBLE;
                GCD_IDX_ROTATE_FUNC: rotate_and_function <= IO_REQ.wdata & GCD_WMASK_ROTFN;
                GCD_IDX_READ_PLANE:  read_plane_select <= IO_REQ.wdata & GCD_WMASK_RDSEL;
                GCD_IDX_GFX_MODE:    gfx_mode <= IO_REQ.wdata & GCD_WMASK_MODE; // RULE12
                GCD_IDX_MISC:        misc_mode <= IO_REQ.wdata & GCD_WMASK_NIBBLE;
                GCD_IDX_DONT_CARE:   dont_care <= IO_REQ.wdata & GCD_WMASK_NIBBLE; // RULE15
                GCD_IDX_BIT_MASK:    bit_mask <= IO_REQ.wdata & GCD_WMASK_FULL; // RULE14
                default:             ;
            endcase
        end
    end

    // latches are only loaded by reads, so writes to readback index are dropped
    // soft reset spares them, so software can still read back after a mode reset
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int p = 0; p < NUM_PLANES; p++) begin
                latch[p] <= GCD_RST_VALUE;
            end
        end else if (MEM_REQ.rd) begin
            for (int p = 0; p < NUM_PLANES; p++) begin
                latch[p] <= plane_byte[p]; // RULE16
            end
        end
    end

    // i/o read answer, one cycle after the request
    // registered so the port mux never reaches the host pins directly
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            IO_RDATA  <= 8'h00;
            IO_RVALID <= 1'b0;
        end else begin
            IO_RVALID <= IO_REQ.rd;
            if (IO_REQ.rd) begin
                IO_RDATA <= next_io_rdata;
            end
        end
    end

    // memory read answer; a read takes priority over a write in the same cycle
    // the dropped write gives no sign, so the host must keep the two apart
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            MEM_RDATA  <= 8'h00;
            MEM_RVALID <= 1'b0;
        end else begin
            MEM_RVALID <= MEM_REQ.rd;
            if (MEM_REQ.rd) begin
                MEM_RDATA <= next_mem_rdata;
            end
        end
    end

    // map write strobe and data, uses latch contents from before this write
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PLANE_WDATA <= 32'h0000_0000;
            PLANE_WE    <= 4'h0;
        end else begin
            PLANE_WE <= 4'h0;
            if (MEM_REQ.wr && !MEM_REQ.rd) begin
                PLANE_WE <= next_we;
                for (int p = 0; p < NUM_PLANES; p++) begin
                    PLANE_WDATA[p*8 +: 8] <= lane_out[p]; // RULE2 RULE12
                end
            end
        end
    end

endmodule : gcd_datapath

`default_nettype wire

/* tb/gcd_datapath_assertions.sv */
// gcd_datapath_assertions: port-level checks of the graphics controller datapath.
// assumes it is bound to gcd_datapath; one clock, async SYS_RST.
`default_nettype none

module gcd_datapath_assertions
    import gcd_pkg::*;
(
    input  wire logic         CLK,
    input  wire logic         SYS_RST,
    input  wire gcd_io_req_s  IO_REQ,
    input  wire logic  [7:0]  IO_RDATA,
    input  wire logic         IO_RVALID,
    input  wire gcd_mem_req_s MEM_REQ,
    input  wire logic  [7:0]  MEM_RDATA,
    input  wire logic         MEM_RVALID,
    input  wire logic  [3:0]  MAP_ENABLE,
    input  wire logic  [3:0]  PLANE_WE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // i/o reads answer in exactly one cycle, and nothing else raises the answer
    a_io_read_answer: assert property (IO_REQ.rd |=> IO_RVALID)
        else $error("io read not answered");
    a_io_valid_cause: assert property (IO_RVALID |-> $past(IO_REQ.rd))
        else $error("io answer without read");
    a_io_data_hold: assert property (!IO_RVALID |-> $stable(IO_RDATA))
        else $error("io read data moved");
    // memory reads likewise
    a_mem_read_answer: assert property (MEM_REQ.rd |=> MEM_RVALID)
        else $error("memory read not answered");
    a_mem_valid_cause: assert property (MEM_RVALID |-> $past(MEM_REQ.rd))
        else $error("memory answer without read");
    a_mem_data_hold: assert property (!MEM_RVALID |-> $stable(MEM_RDATA))
        else $error("memory read data moved");
    // map strobes come only from a lone write and stay within the enabled maps
    a_we_write_cause: assert property (|PLANE_WE |-> $past(MEM_REQ.wr) && !$past(MEM_REQ.rd))
        else $error("map strobe without write");
    a_we_map_enable: assert property ((PLANE_WE & ~$past(MAP_ENABLE)) == 4'h0)
        else $error("strobe on disabled map");
    a_we_write_answer: assert property (
        MEM_REQ.wr && !MEM_REQ.rd && MAP_ENABLE == 4'hf |=> PLANE_WE != 4'h0)
        else $error("write produced no strobe");

    c_io_read: cover property (IO_RVALID);
    c_mem_read: cover property (MEM_RVALID);
    c_all_maps: cover property (PLANE_WE == 4'hf);
endmodule : gcd_datapath_assertions

`default_nettype wire

/* tb/gcd_plane_mem.sv */
// gcd_plane_mem: the four display maps, one byte each for the addressed place.
// assumes one byte address at a time; reads answer at once, writes on PLANE_WE.
`default_nettype none

module gcd_plane_mem (
    input  wire logic        CLK,
    input  wire logic [3:0]  PLANE_WE,
    input  wire logic [31:0] PLANE_WDATA,
    output logic      [31:0] PLANE_RDATA
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [4] = '{default: 8'h00};

    // address not modelled: one byte stands for the location under test
    assign PLANE_RDATA = {mem[3], mem[2], mem[1], mem[0]};

    // each map takes its own lane only when its strobe is up
    always @(posedge CLK) begin
        for (int n = 0; n < 4; n++) begin
            if (PLANE_WE[n]) begin
                mem[n] <= PLANE_WDATA[8*n +: 8];
            end
        end
    end
endmodule : gcd_plane_mem

`default_nettype wire

/* tb/gcd_datapath_test.sv */
// gcd_datapath_test: directed bench of the graphics controller datapath.
// assumes gcd_plane_mem as the display maps; inputs move at the falling edge.
`default_nettype none

module gcd_datapath_test
    import gcd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         soft_rst = 1'b0;
    gcd_io_req_s  io_req = '0;
    gcd_mem_req_s mem_req = '0;
    logic [7:0]   io_rdata, mem_rdata;
    logic         io_rvalid, mem_rvalid;
    logic [31:0]  pl_rdata, pl_wdata;
    logic [3:0]   pl_we;
    logic [3:0]   map_en = 4'hf;
    int           n_errors = 0;
    int           tests_run = 0;

    always #25 clk = ~clk;

    gcd_datapath dut_u (.CLK(clk), .SYS_RST(sys_rst), .SOFT_RST(soft_rst),
        .IO_REQ(io_req), .IO_RDATA(io_rdata), .IO_RVALID(io_rvalid),
        .MEM_REQ(mem_req), .MEM_RDATA(mem_rdata), .MEM_RVALID(mem_rvalid),
        .MAP_ENABLE(map_en), .PLANE_RDATA(pl_rdata), .PLANE_WDATA(pl_wdata),
        .PLANE_WE(pl_we));
    gcd_plane_mem mdl_u (.CLK(clk), .PLANE_WE(pl_we), .PLANE_WDATA(pl_wdata),
        .PLANE_RDATA(pl_rdata));

    task automatic complete_run();
        if (n_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one-cycle request pulses, dropped at the next falling edge
    task automatic io_acc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk);
        io_req = '0;
        if (!w) chk({7'h0, io_rvalid}, 8'h01);
    endtask : io_acc

    task automatic gc_wr(input logic [3:0] i, input logic [7:0] d);
        io_acc(1'b1, GCD_PORT_GC_INDEX, {4'h0, i});
        io_acc(1'b1, GCD_PORT_GC_DATA, d);
    endtask : gc_wr

    task automatic gc_chk(input logic [3:0] i, input logic [7:0] e);
        io_acc(1'b1, GCD_PORT_GC_INDEX, {4'h0, i});
        io_acc(1'b0, GCD_PORT_GC_DATA, 8'h00);
        chk(io_rdata, e);
    endtask : gc_chk

    task automatic mem_rd(input logic a0, input logic [7:0] e);
        @(negedge clk);
        mem_req = '{wr: 1'b0, rd: 1'b1, a0: a0, wdata: 8'h00};
        @(negedge clk);
        mem_req = '0;
        chk({7'h0, mem_rvalid}, 8'h01);
        chk(mem_rdata, e);
    endtask : mem_rd

    // waits one more edge so the map model has taken the strobe
    task automatic mem_wr(input logic [7:0] d, input logic [7:0] e0, input logic [7:0] e1);
        @(negedge clk);
        mem_req = '{wr: 1'b1, rd: 1'b0, a0: 1'b0, wdata: d};
        @(negedge clk);
        mem_req = '0;
        @(negedge clk);
        chk(mdl_u.mem[0], e0);
        chk(mdl_u.mem[1], e1);
    endtask : mem_wr

    function automatic logic [7:0] alu(input logic [1:0] f, input logic [7:0] d, l);
        case (f)
            GCD_FN_AND: return d & l;
            GCD_FN_OR:  return d | l;
            GCD_FN_XOR: return d ^ l;
            default:    return d;
        endcase
    endfunction : alu

    // maps and latches become ff,00,ff,00 with plain settings
    task automatic prep();
        logic [7:0] v [9] = '{8'h05, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f, 8'hff};
        foreach (v[i]) gc_wr(i[3:0], v[i]);
        mem_wr(8'h00, 8'hff, 8'h00);
        mem_rd(1'b0, 8'hff);
    endtask : prep

    // hang guard, far beyond the fewer than a thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        complete_run();
    end

    initial begin
        logic [7:0] wm [9] = '{GCD_WMASK_NIBBLE, GCD_WMASK_NIBBLE, GCD_WMASK_NIBBLE,
            GCD_WMASK_ROTFN, GCD_WMASK_RDSEL, GCD_WMASK_MODE, GCD_WMASK_NIBBLE,
            GCD_WMASK_NIBBLE, GCD_WMASK_FULL};
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        foreach (wm[i]) gc_chk(i[3:0], GCD_RST_VALUE);
        io_acc(1'b1, GCD_PORT_GC_INDEX, 8'hff);
        io_acc(1'b0, GCD_PORT_GC_INDEX, 8'h00);
        chk(io_rdata, 8'h0f);
        foreach (wm[i]) begin
            gc_wr(i[3:0], 8'hff);
            gc_chk(i[3:0], wm[i]);
        end
        gc_wr(4'h9, 8'hff);
        gc_chk(4'h9, 8'h00);
        @(negedge clk);
        soft_rst = 1'b1;
        @(negedge clk);
        soft_rst = 1'b0;
        gc_chk(GCD_IDX_BIT_MASK, GCD_RST_VALUE);
        prep();
        for (int i = 0; i < 4; i++) begin
            gc_wr(GCD_IDX_READ_PLANE, i[7:0]);
            mem_rd(1'b0, i[0] ? 8'h00 : 8'hff);
            io_acc(1'b1, GCD_PORT_CRT_IDX_C, GCD_CRT_IDX_LATCH_RB);
            io_acc(1'b0, GCD_PORT_CRT_DAT_C, 8'h00);
            chk(io_rdata, i[0] ? 8'h00 : 8'hff);
        end
        gc_wr(GCD_IDX_GFX_MODE, 8'h08);
        mem_rd(1'b0, 8'h00);
        gc_wr(GCD_IDX_COMPARE, 8'h05);
        mem_rd(1'b0, 8'hff);
        gc_wr(GCD_IDX_DONT_CARE, 8'h0a);
        gc_wr(GCD_IDX_COMPARE, 8'h00);
        mem_rd(1'b0, 8'hff);
        for (int f = 0; f < 4; f++) begin
            prep();
            gc_wr(GCD_IDX_ROTATE_FUNC, {3'h0, f[1:0], 3'h1});
            gc_wr(GCD_IDX_FILL_ENABLE, 8'h00);
            mem_wr(8'h81, alu(f[1:0], 8'hc0, 8'hff), alu(f[1:0], 8'hc0, 8'h00));
        end
        prep();
        gc_wr(GCD_IDX_FILL_ENABLE, 8'h00);
        gc_wr(GCD_IDX_BIT_MASK, 8'h0f);
        mem_wr(8'h3c, 8'hfc, 8'h0c);
        prep();
        gc_wr(GCD_IDX_FILL_VALUE, 8'h0a);
        mem_wr(8'h00, 8'h00, 8'hff);
        gc_wr(GCD_IDX_GFX_MODE, {6'h0, GCD_WM_LATCH});
        mem_wr(8'h55, 8'hff, 8'h00);
        prep();
        gc_wr(GCD_IDX_ROTATE_FUNC, 8'h01);
        gc_wr(GCD_IDX_GFX_MODE, {6'h0, GCD_WM_BIT_FILL});
        mem_wr(8'h0a, 8'h00, 8'hff);
        prep();
        gc_wr(GCD_IDX_FILL_ENABLE, 8'h00);
        gc_wr(GCD_IDX_FILL_VALUE, 8'h0a);
        gc_wr(GCD_IDX_GFX_MODE, {6'h0, GCD_WM_MASKED});
        mem_wr(8'h0f, 8'hf0, 8'h0f);
        prep();
        map_en = 4'h1;
        gc_wr(GCD_IDX_FILL_VALUE, 8'h0a);
        mem_wr(8'h00, 8'h00, 8'h00);
        map_en = 4'hf;
        prep();
        gc_wr(GCD_IDX_MISC, 8'h02);
        gc_wr(GCD_IDX_READ_PLANE, 8'h03);
        mem_rd(1'b1, 8'h00);
        mem_rd(1'b0, 8'hff);
        gc_wr(GCD_IDX_READ_PLANE, 8'h01);
        mem_rd(1'b0, 8'hff);
        gc_wr(GCD_IDX_FILL_VALUE, 8'h0a);
        mem_wr(8'h00, 8'h00, 8'h00);
        complete_run();
    end
endmodule : gcd_datapath_test

bind gcd_datapath gcd_datapath_assertions chk_u (.CLK(CLK), .SYS_RST(SYS_RST),
    .IO_REQ(IO_REQ), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID), .MEM_REQ(MEM_REQ),
    .MEM_RDATA(MEM_RDATA), .MEM_RVALID(MEM_RVALID), .MAP_ENABLE(MAP_ENABLE),
    .PLANE_WE(PLANE_WE));

`default_nettype wire
